// file: spp_pkg.sv
/*
 * Constants, register layout and pin carrier for the serial peripheral port.
 * Assumes an eight-byte register window reached by a 3-bit index on a plain port.
 */
package spp_pkg;
	// Register indices
	localparam logic [2:0] SPP_OFS_CONTROL_ONE = 3'h0;
	localparam logic [2:0] SPP_OFS_CONTROL_TWO = 3'h1;
	localparam logic [2:0] SPP_OFS_RATE_SELECT = 3'h2;
	localparam logic [2:0] SPP_OFS_PORT_STATUS = 3'h3;
	localparam logic [2:0] SPP_OFS_RESERVED_A = 3'h4;
	localparam logic [2:0] SPP_OFS_BYTE_BUFFER = 3'h5;
	localparam logic [2:0] SPP_OFS_RESERVED_B = 3'h6;
	localparam logic [2:0] SPP_OFS_RESERVED_C = 3'h7;

	// control_one fields
	localparam int SPP_C1_XFER_IRQ_EN = 7;
	localparam int SPP_C1_MODULE_ON = 6;
	localparam int SPP_C1_TXE_IRQ_EN = 5;
	localparam int SPP_C1_MASTER = 4;
	localparam int SPP_C1_IDLE_LEVEL = 3;
	localparam int SPP_C1_PHASE = 2;
	localparam int SPP_C1_SEL_OUT_EN = 1;
	localparam int SPP_C1_LSB_FIRST = 0;

	// control_two fields
	localparam int SPP_C2_FAULT_EN = 4;
	localparam int SPP_C2_BIDIR_OE = 3;
	localparam int SPP_C2_HALT_WAIT = 1;
	localparam int SPP_C2_PIN_CFG = 0;
	localparam logic [7:0] SPP_C2_WMASK = 8'h1b;

	// rate_select fields
	localparam int SPP_RS_PRE_LSB = 4;
	localparam int SPP_RS_RATE_LSB = 0;
	localparam logic [7:0] SPP_RS_WMASK = 8'h77;

	// port_status fields
	localparam int SPP_ST_XFER_DONE = 7;
	localparam int SPP_ST_TX_EMPTY = 5;
	localparam int SPP_ST_MODE_FAULT = 4;

	// Reset values
	localparam logic [7:0] SPP_RST_CONTROL_ONE = 8'h04;
	localparam logic [7:0] SPP_RST_CONTROL_TWO = 8'h00;
	localparam logic [7:0] SPP_RST_RATE_SELECT = 8'h00;

	// Transfer timing: 8 bits, two clock edges each
	localparam logic [4:0] SPP_EDGES_PER_BYTE = 5'h10;
	localparam logic [10:0] SPP_ONE = 11'h001;

	typedef enum logic {
		SPP_IDLE,
		SPP_SHIFT
	} spp_state_t;

	// Pin drive toward the pads; each oe high while this block drives the pin
	typedef struct packed {
		logic sck;
		logic sck_oe;
		logic mosi;
		logic mosi_oe;
		logic miso;
		logic miso_oe;
		logic ss_n;
		logic ss_n_oe;
	} spp_pin_out_t;
endpackage

// file: spp_port.sv
/*
 * Serial peripheral port: master/slave 8-bit full-duplex shifter with
 * register window, baud divider, slave-select handling and bidirectional pins.
 * Assumes pins arrive asynchronously and wait/stop indications come from
 * logic on ref_clk_i. Interrupt request is a level for the processor.
 */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module spp_port #(
	parameter int SYNC_STAGES = 3
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic wait_i,
	input wire logic stop_i,
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic miso_i,
	input wire logic ss_n_i,
	output spp_pkg::spp_pin_out_t pins_o,
	output logic irq_o
);
	logic [7:0] ctrl1_ff;
	logic [7:0] ctrl2_ff;
	logic [7:0] rate_ff;
	logic [7:0] rdata_ff;
	logic done_flag_ff;
	logic txe_flag_ff;
	logic fault_flag_ff;
	logic done_arm_ff;
	logic txe_arm_ff;
	logic fault_arm_ff;
	logic [7:0] tx_buf_ff;
	logic tx_full_ff;
	logic [7:0] rx_data_ff;
	logic [7:0] tx_sr_ff;
	logic [7:0] rx_sr_ff;
	logic [4:0] edges_ff;
	logic [10:0] cnt_ff;
	spp_pkg::spp_state_t state_ff;
	logic [SYNC_STAGES-1:0] sync_ff [4];
	logic [3:0] filt_ff;
	logic sck_prev_ff;

	logic on;
	logic master;
	logic clock_idle_level;
	logic clock_phase_select;
	logic lsb_first;
	logic fault_en;
	logic bidir;
	logic halt;
	logic sck_f;
	logic mosi_f;
	logic miso_f;
	logic ss_f;
	logic fault_now;
	logic load_now;
	logic tick;
	logic m_edge;
	logic m_done;
	logic s_edge;
	logic s_done;
	logic xfer_done;
	logic edge_now;
	logic [4:0] n_edge;
	logic sample;
	logic shift;
	logic rx_bit;
	logic tx_bit;
	logic [7:0] rx_shifted;
	logic [10:0] half_m1;
	logic wr_data;
	logic rd_data;
	logic rd_status;

	assign on = ctrl1_ff[spp_pkg::SPP_C1_MODULE_ON];
	assign master = ctrl1_ff[spp_pkg::SPP_C1_MASTER];
	assign clock_idle_level = ctrl1_ff[spp_pkg::SPP_C1_IDLE_LEVEL];
	assign clock_phase_select = ctrl1_ff[spp_pkg::SPP_C1_PHASE];
	assign lsb_first = ctrl1_ff[spp_pkg::SPP_C1_LSB_FIRST];
	assign fault_en = ctrl2_ff[spp_pkg::SPP_C2_FAULT_EN];
	assign bidir = ctrl2_ff[spp_pkg::SPP_C2_PIN_CFG];
	assign wr_data = wr_i && (addr_i == spp_pkg::SPP_OFS_BYTE_BUFFER);
	assign rd_data = rd_i && (addr_i == spp_pkg::SPP_OFS_BYTE_BUFFER);
	assign rd_status = rd_i && (addr_i == spp_pkg::SPP_OFS_PORT_STATUS);

	// Pin synchronisers; a level counts only once the last two stages agree
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			logic pin_in;
			if (gi == 0) begin : g_sck
				assign pin_in = sck_i;
			end else if (gi == 1) begin : g_mosi
				assign pin_in = mosi_i;
			end else if (gi == 2) begin : g_miso
				assign pin_in = miso_i;
			end else begin : g_ss
				assign pin_in = ss_n_i;
			end
			always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					sync_ff[gi] <= '1;
					filt_ff[gi] <= 1'b1;
				end else begin
					sync_ff[gi] <= {sync_ff[gi][SYNC_STAGES-2:0], pin_in};
					if (sync_ff[gi][SYNC_STAGES-1] == sync_ff[gi][SYNC_STAGES-2]) begin
						filt_ff[gi] <= sync_ff[gi][SYNC_STAGES-1];
					end
				end
			end
		end
	endgenerate

	assign sck_f = filt_ff[0];
	assign mosi_f = filt_ff[1];
	assign miso_f = filt_ff[2];
	assign ss_f = filt_ff[3];

	// Master stalls in stop, and in wait when halt-in-wait is set
	assign halt = stop_i || (wait_i && ctrl2_ff[spp_pkg::SPP_C2_HALT_WAIT]);

	// Fault only while the select pin is an input watched for faults
	assign fault_now = on && master && fault_en && !ctrl1_ff[spp_pkg::SPP_C1_SEL_OUT_EN] && !ss_f;

	// Half period of SCK in bus cycles: (prescale+1) * 2^rate
	assign half_m1 = (({7'h00, 1'b0, rate_ff[6:4]} + spp_pkg::SPP_ONE) << rate_ff[2:0]) - spp_pkg::SPP_ONE;

	assign load_now = on && !fault_now && tx_full_ff && (state_ff == spp_pkg::SPP_IDLE)
		&& (master ? !halt : !ss_f);
	assign tick = on && master && !halt && (state_ff == spp_pkg::SPP_SHIFT) && (cnt_ff == half_m1);
	assign m_done = tick && ((edges_ff == spp_pkg::SPP_EDGES_PER_BYTE)
		|| (!clock_phase_select && (edges_ff == spp_pkg::SPP_EDGES_PER_BYTE - 5'h01)));
	assign m_edge = tick && (edges_ff != spp_pkg::SPP_EDGES_PER_BYTE);
	// Slave follows SCK even in wait or stop to stay in step with the master
	assign s_edge = on && !master && !ss_f && (state_ff == spp_pkg::SPP_SHIFT) && (sck_f != sck_prev_ff);
	assign s_done = s_edge && (edges_ff == spp_pkg::SPP_EDGES_PER_BYTE - 5'h01);
	assign xfer_done = m_done || s_done;
	assign edge_now = m_edge || s_edge;
	assign n_edge = edges_ff + 5'h01;
	// Odd edges lead; phase decides whether leading edges sample or shift
	assign sample = edge_now && (n_edge[0] ^ clock_phase_select);
	assign shift = edge_now && !(n_edge[0] ^ clock_phase_select) && (n_edge != 5'h01);
	assign rx_bit = master ? (bidir ? mosi_f : miso_f) : (bidir ? miso_f : mosi_f);
	assign tx_bit = lsb_first ? tx_sr_ff[0] : tx_sr_ff[7];
	assign rx_shifted = lsb_first ? {rx_bit, rx_sr_ff[7:1]} : {rx_sr_ff[6:0], rx_bit};

	// Control registers; reserved bits held at zero
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl1_ff <= spp_pkg::SPP_RST_CONTROL_ONE;
			ctrl2_ff <= spp_pkg::SPP_RST_CONTROL_TWO;
			rate_ff <= spp_pkg::SPP_RST_RATE_SELECT;
		end else begin
			if (wr_i && addr_i == spp_pkg::SPP_OFS_CONTROL_ONE) begin
				ctrl1_ff <= wdata_i;
			end
			if (wr_i && addr_i == spp_pkg::SPP_OFS_CONTROL_TWO) begin
				ctrl2_ff <= wdata_i & spp_pkg::SPP_C2_WMASK;
			end
			if (wr_i && addr_i == spp_pkg::SPP_OFS_RATE_SELECT) begin
				rate_ff <= wdata_i & spp_pkg::SPP_RS_WMASK;
			end
			// A fault drops the port to slave so two masters stop fighting
			if (fault_now) begin
				ctrl1_ff[spp_pkg::SPP_C1_MASTER] <= 1'b0;
			end
		end
	end

	// Status flags; each clears only after a status read saw it set, and a set beats a clear
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			done_flag_ff <= 1'b0;
			txe_flag_ff <= 1'b1;
			fault_flag_ff <= 1'b0;
			done_arm_ff <= 1'b0;
			txe_arm_ff <= 1'b0;
			fault_arm_ff <= 1'b0;
		end else begin
			if (rd_status && done_flag_ff) begin
				done_arm_ff <= 1'b1;
			end else if (rd_data) begin
				done_arm_ff <= 1'b0;
			end
			if (rd_status && txe_flag_ff) begin
				txe_arm_ff <= 1'b1;
			end else if (wr_data) begin
				txe_arm_ff <= 1'b0;
			end
			if (rd_status && fault_flag_ff) begin
				fault_arm_ff <= 1'b1;
			end else if (wr_i && addr_i == spp_pkg::SPP_OFS_CONTROL_ONE) begin
				fault_arm_ff <= 1'b0;
			end
			if (xfer_done) begin
				done_flag_ff <= 1'b1;
			end else if (rd_data && done_arm_ff) begin
				done_flag_ff <= 1'b0;
			end
			if (load_now) begin
				txe_flag_ff <= 1'b1;
			end else if (wr_data && txe_arm_ff) begin
				txe_flag_ff <= 1'b0;
			end
			if (fault_now) begin
				fault_flag_ff <= 1'b1;
			end else if (wr_i && addr_i == spp_pkg::SPP_OFS_CONTROL_ONE && fault_arm_ff) begin
				fault_flag_ff <= 1'b0;
			end
		end
	end

	// Transmit buffer; a write without a prior armed status read is dropped
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tx_buf_ff <= 8'h00;
			tx_full_ff <= 1'b0;
		end else begin
			if (wr_data && txe_arm_ff && txe_flag_ff) begin
				tx_buf_ff <= wdata_i;
				tx_full_ff <= 1'b1;
			end else if (load_now) begin
				tx_full_ff <= 1'b0;
			end
		end
	end

	// Baud divider, running only while a master byte is on the wire
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_ff <= 11'h000;
		end else begin
			if (state_ff != spp_pkg::SPP_SHIFT || !master || tick) begin
				cnt_ff <= 11'h000;
			end else if (!halt) begin
				cnt_ff <= cnt_ff + spp_pkg::SPP_ONE;
			end
		end
	end

	// Shift engine shared by master and slave
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_ff <= spp_pkg::SPP_IDLE;
			edges_ff <= 5'h00;
			tx_sr_ff <= 8'h00;
			rx_sr_ff <= 8'h00;
			// Matches the filter's reset level so no false edge follows reset
			sck_prev_ff <= 1'b1;
		end else begin
			sck_prev_ff <= sck_f;
			if (!on || fault_now || (!master && ss_f)) begin
				state_ff <= spp_pkg::SPP_IDLE;
				edges_ff <= 5'h00;
			end else begin
				case (state_ff)
					spp_pkg::SPP_IDLE: begin
						if (load_now) begin
							tx_sr_ff <= tx_buf_ff;
						end
						// Slave shifts whatever is in the shifter if nothing was queued
						if (load_now || !master) begin
							state_ff <= spp_pkg::SPP_SHIFT;
							// Phase 1 master issues its first edge at once
							edges_ff <= (master && clock_phase_select) ? 5'h01 : 5'h00;
						end
					end
					spp_pkg::SPP_SHIFT: begin
						if (xfer_done) begin
							state_ff <= spp_pkg::SPP_IDLE;
							edges_ff <= 5'h00;
						end else if (edge_now) begin
							edges_ff <= n_edge;
						end
						if (sample) begin
							rx_sr_ff <= rx_shifted;
						end
						if (shift) begin
							tx_sr_ff <= lsb_first ? {1'b0, tx_sr_ff[7:1]} : {tx_sr_ff[6:0], 1'b0};
						end
					end
					default: begin
						state_ff <= spp_pkg::SPP_IDLE;
						edges_ff <= 5'h00;
					end
				endcase
			end
		end
	end

	// Received byte lands in the data register at end of transfer
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_data_ff <= 8'h00;
		end else if (xfer_done) begin
			rx_data_ff <= sample ? rx_shifted : rx_sr_ff;
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_ff <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				spp_pkg::SPP_OFS_CONTROL_ONE: rdata_ff <= ctrl1_ff;
				spp_pkg::SPP_OFS_CONTROL_TWO: rdata_ff <= ctrl2_ff;
				spp_pkg::SPP_OFS_RATE_SELECT: rdata_ff <= rate_ff;
				spp_pkg::SPP_OFS_PORT_STATUS: begin
					rdata_ff <= 8'h00;
					rdata_ff[spp_pkg::SPP_ST_XFER_DONE] <= done_flag_ff;
					rdata_ff[spp_pkg::SPP_ST_TX_EMPTY] <= txe_flag_ff;
					rdata_ff[spp_pkg::SPP_ST_MODE_FAULT] <= fault_flag_ff;
				end
				spp_pkg::SPP_OFS_BYTE_BUFFER: rdata_ff <= rx_data_ff;
				default: rdata_ff <= 8'h00;
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end
	assign rdata_o = rdata_ff;

	assign irq_o = (ctrl1_ff[spp_pkg::SPP_C1_XFER_IRQ_EN] && (done_flag_ff || fault_flag_ff))
		|| (ctrl1_ff[spp_pkg::SPP_C1_TXE_IRQ_EN] && txe_flag_ff);

	// Pin drive; SCK level follows edge parity so it rests at the idle level
	always_comb begin
		pins_o = '0;
		pins_o.sck = clock_idle_level ^ (master && state_ff == spp_pkg::SPP_SHIFT && edges_ff[0]);
		pins_o.sck_oe = on && master;
		pins_o.mosi = tx_bit;
		pins_o.miso = tx_bit;
		if (bidir) begin
			pins_o.mosi_oe = on && master && ctrl2_ff[spp_pkg::SPP_C2_BIDIR_OE];
			pins_o.miso_oe = on && !master && !ss_f && ctrl2_ff[spp_pkg::SPP_C2_BIDIR_OE];
		end else begin
			pins_o.mosi_oe = on && master;
			pins_o.miso_oe = on && !master && !ss_f;
		end
		// Select driven low for the byte only in master output mode; slave never drives it
		pins_o.ss_n = !(master && state_ff == spp_pkg::SPP_SHIFT);
		pins_o.ss_n_oe = on && master && fault_en && ctrl1_ff[spp_pkg::SPP_C1_SEL_OUT_EN];
	end
endmodule

// file: spp_asserts.sv
/* Checker for spp_port: pin drive, irq and read-port relations.
   Sees only the port's pins; shadows control writes itself. */
`timescale 1ns/1ps
module spp_asserts #(
	parameter int SYNC_STAGES = 3
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic wait_i,
	input wire logic stop_i,
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic miso_i,
	input wire logic ss_n_i,
	input wire spp_pkg::spp_pin_out_t pins_o,
	input wire logic irq_o
);
	logic [7:0] c1_ff;
	logic [7:0] c2_ff;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	// Misses the fault clear of master_select, so only one-way implications use bit 4
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) c1_ff <= spp_pkg::SPP_RST_CONTROL_ONE;
		else if (wr_i && addr_i == spp_pkg::SPP_OFS_CONTROL_ONE) c1_ff <= wdata_i;
	end
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) c2_ff <= spp_pkg::SPP_RST_CONTROL_TWO;
		else if (wr_i && addr_i == spp_pkg::SPP_OFS_CONTROL_TWO) c2_ff <= wdata_i & spp_pkg::SPP_C2_WMASK;
	end
	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("rdata_o busy with no read");
	a_rsvd_reads: assert property ($past(rd_i) && $past(addr_i) inside {3'h4, 3'h6, 3'h7} |-> rdata_o == 8'h00)
		else $error("reserved offset read not zero");
	a_c2_masked: assert property ($past(rd_i) && $past(addr_i) == 3'h1 |-> rdata_o == c2_ff)
		else $error("control_two read mismatch");
	a_irq_masked: assert property (!c1_ff[7] && !c1_ff[5] |-> !irq_o) else $error("irq with enables off");
	a_off_released: assert property (!c1_ff[6] |-> !(pins_o.sck_oe || pins_o.mosi_oe || pins_o.miso_oe || pins_o.ss_n_oe))
		else $error("pin driven while module off");
	a_sck_idle: assert property (pins_o.sck_oe && pins_o.ss_n |-> pins_o.sck == c1_ff[3])
		else $error("sck idle level wrong");
	a_sck_master: assert property (pins_o.sck_oe |-> c1_ff[4]) else $error("sck driven as slave");
	a_ss_output: assert property (pins_o.ss_n_oe |-> c1_ff[4] && c1_ff[1] && c2_ff[4])
		else $error("ss_n driven without both enables");
	a_mosi_slave: assert property (!c1_ff[4] && !c2_ff[0] |-> !pins_o.mosi_oe) else $error("slave drives mosi");
	a_bidir_master: assert property (c2_ff[0] && pins_o.sck_oe |-> !pins_o.miso_oe)
		else $error("bidir master drives miso");
	a_halt_freeze: assert property ((wait_i && c2_ff[1] && pins_o.sck_oe) [*3] |-> $stable(pins_o.sck))
		else $error("sck moves in halted wait");
	c_irq: cover property ($rose(irq_o));
	c_ss_out: cover property (pins_o.ss_n_oe);
	c_byte: cover property ($fell(pins_o.ss_n));
endmodule
bind spp_port spp_asserts #(.SYNC_STAGES(SYNC_STAGES)) u_chk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .wait_i(wait_i),
	.stop_i(stop_i), .sck_i(sck_i), .mosi_i(mosi_i), .miso_i(miso_i), .ss_n_i(ss_n_i), .pins_o(pins_o),
	.irq_o(irq_o));

// file: spp_peer.sv
/* Serial slave facing the port when it runs as master, phase 0 only.
   Assumes sck and ss_n come from the port and move on clk_i edges. */
`timescale 1ns/1ps
module spp_peer (
	input wire logic clk_i,
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic ss_n_i,
	input wire logic clock_idle_level_i,
	input wire logic lsb_i,
	input wire logic [7:0] tx_i,
	output logic miso_o,
	output logic [7:0] rx_o
);
	logic lead;
	logic lead_ff = 1'b0;
	logic ss_ff = 1'b1;
	logic bit_ff = 1'b0;
	logic junk_ff = 1'b0;
	assign lead = sck_i ^ clock_idle_level_i;
	// Deselected line toggles so a stale bit cannot pass for data
	assign miso_o = ss_n_i ? junk_ff : (lsb_i ? rx_o[0] : rx_o[7]);
	always @(posedge clk_i) begin
		junk_ff <= ~junk_ff;
		lead_ff <= lead;
		ss_ff <= ss_n_i;
		if (ss_ff && !ss_n_i) rx_o <= tx_i;
		else if (!ss_n_i && !lead_ff && lead) bit_ff <= mosi_i;
		// Last trailing edge comes with the select release, so judge it by the select one cycle back
		else if (!ss_ff && lead_ff && !lead) rx_o <= lsb_i ? {bit_ff, rx_o[7:1]} : {rx_o[6:0], bit_ff};
	end
endmodule

// file: test_serial_peripheral_port.sv
/* Bench for spp_port as master against one serial slave model.
   Assumes the sck and mosi pad inputs loop back from the port's own pin drive; miso comes from the slave model, ss_n from the bench. */
`timescale 1ns/1ps
module test_serial_peripheral_port;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic wt = 1'b0;
	logic stp = 1'b0;
	logic ss_drv = 1'b1;
	logic lsb = 1'b0;
	logic clock_idle_level = 1'b0;
	logic [7:0] ptx = 8'h00;
	logic [7:0] rdata;
	logic irq;
	logic pmiso;
	logic [7:0] prx;
	spp_pkg::spp_pin_out_t pins;
	int fails = 0;
	int n_tests = 0;
	spp_port dut (.ref_clk_i(clk), .sys_rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .wait_i(wt), .stop_i(stp), .sck_i(pins.sck), .mosi_i(pins.mosi),
		.miso_i(pins.miso_oe ? pins.miso : pmiso), .ss_n_i(ss_drv), .pins_o(pins), .irq_o(irq));
	spp_peer peer (.clk_i(clk), .sck_i(pins.sck), .mosi_i(pins.mosi), .ss_n_i(pins.ss_n), .clock_idle_level_i(clock_idle_level),
		.lsb_i(lsb), .tx_i(ptx), .miso_o(pmiso), .rx_o(prx));
	initial forever #20 clk = ~clk;
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		chk($sformatf("register %0d", a), exp, d);
	endtask
	task automatic t_regs;
		logic [2:0] rsv[3] = '{3'h4, 3'h6, 3'h7};
		rchk(3'h0, 8'h04);
		rchk(3'h1, 8'h00);
		rchk(3'h2, 8'h00);
		rchk(3'h3, 8'h20);
		wr_reg(3'h3, 8'h00);
		rchk(3'h3, 8'h20);
		foreach (rsv[i]) begin
			wr_reg(rsv[i], 8'hff);
			rchk(rsv[i], 8'h00);
		end
		wr_reg(3'h1, 8'hff);
		rchk(3'h1, 8'h1b);
		wr_reg(3'h2, 8'hff);
		rchk(3'h2, 8'h77);
		wr_reg(3'h0, 8'h60);
		chk("irq_o", 8'h01, {7'h00, irq});
		wr_reg(3'h0, 8'h40);
		chk("irq_o", 8'h00, {7'h00, irq});
		$display("register test done");
	endtask
	task automatic t_xfer(input logic [7:0] c1, input logic [7:0] tx, input logic [7:0] p, input logic halt);
		logic [7:0] d;
		logic [7:0] k;
		logic s0;
		lsb = c1[0];
		clock_idle_level = c1[3];
		ptx = p;
		wr_reg(3'h1, halt ? 8'h02 : 8'h00);
		wr_reg(3'h2, 8'h13);
		wr_reg(3'h0, c1);
		chk("sck_oe", 8'h01, {7'h00, pins.sck_oe});
		chk("sck idle", {7'h00, clock_idle_level}, {7'h00, pins.sck});
		rd_reg(3'h3, d);
		wr_reg(3'h5, tx);
		k = 8'h00;
		while (pins.sck === clock_idle_level && k < 8'hc8) begin
			@(posedge clk) #1 k++;
		end
		k = 8'h00;
		while (pins.sck !== clock_idle_level && k < 8'hc8) begin
			@(posedge clk) #1 k++;
		end
		chk("half period", 8'h10, k);
		if (halt) begin
			@(posedge clk) wt <= 1'b1;
			repeat (3) @(posedge clk);
			#1 s0 = pins.sck;
			k = 8'h00;
			repeat (100) @(posedge clk) #1 k += {7'h00, pins.sck !== s0};
			chk("sck frozen", 8'h00, k);
			@(posedge clk) wt <= 1'b0;
		end
		d = 8'h00;
		for (int i = 0; i < 400 && d[7] !== 1'b1; i++) rd_reg(3'h3, d);
		chk("xfer_done", 8'h01, {7'h00, d[7]});
		rd_reg(3'h5, d);
		chk("received byte", p, d);
		chk("peer byte", tx, prx);
		$display("transfer test done");
	endtask
	task automatic t_fault(input logic [7:0] c2);
		logic [7:0] d;
		wr_reg(3'h1, c2);
		wr_reg(3'h0, 8'h52);
		chk("ss_n_oe", {7'h00, c2[4]}, {7'h00, pins.ss_n_oe});
		wr_reg(3'h0, 8'hd0);
		chk("irq_o", 8'h00, {7'h00, irq});
		@(posedge clk) ss_drv <= 1'b0;
		repeat (10) @(posedge clk);
		rd_reg(3'h3, d);
		chk("mode_fault_flag", {7'h00, c2[4]}, {7'h00, d[4]});
		rchk(3'h0, c2[4] ? 8'hc0 : 8'hd0);
		chk("irq_o", {7'h00, c2[4]}, {7'h00, irq});
		@(posedge clk) ss_drv <= 1'b1;
		wr_reg(3'h1, 8'h00);
		rd_reg(3'h3, d);
		chk("mode_fault_flag kept", {7'h00, c2[4]}, {7'h00, d[4]});
		$display("fault test done");
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#400000;
		fails++;
		close_out();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_xfer(8'h50, 8'ha5, 8'h3c, 1'b0);
		t_xfer(8'h59, 8'h1e, 8'hc7, 1'b0);
		t_xfer(8'h50, 8'h96, 8'h5a, 1'b1);
		t_fault(8'h00);
		t_fault(8'h10);
		close_out();
	end
endmodule
